// ### hdl/flash_guard_pkg.sv
// constants and shared types of the flash access guard
// assumes a 16-bit cpu data path and word-aligned AXI4-Lite register access
package flash_guard_pkg;

	// ----------------------------------------------------------------
	// register map: printed indices, byte address is four times each
	// ----------------------------------------------------------------
	localparam int AXI_ADDR_W = 12;
	localparam logic [11:0] IDX_CTL_ONE = 12'h128;
	localparam logic [11:0] IDX_CTL_TWO = 12'h12A;
	localparam logic [11:0] IDX_CTL_THREE = 12'h12C;
	localparam logic [11:0] IDX_IRQ_EN = 12'h12E;
	localparam logic [11:0] ADDR_CTL_ONE = 12'(IDX_CTL_ONE << 2);
	localparam logic [11:0] ADDR_CTL_TWO = 12'(IDX_CTL_TWO << 2);
	localparam logic [11:0] ADDR_CTL_THREE = 12'(IDX_CTL_THREE << 2);
	localparam logic [11:0] ADDR_IRQ_EN = 12'(IDX_IRQ_EN << 2);

	// ----------------------------------------------------------------
	// passwords, reset values, opcode
	// ----------------------------------------------------------------
	localparam logic [7:0] WRITE_PASSWORD = 8'hA5;
	localparam logic [7:0] READ_PASSWORD = 8'h96;
	localparam logic [7:0] RST_CTL_ONE = 8'h00;
	localparam logic [7:0] RST_CTL_TWO = 8'h42;
	localparam logic [15:0] JMP_SELF_OPCODE = 16'h3FFF;
	localparam logic [7:0] CTL_ONE_MASK = 8'hDE;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int B1_ERASE = 1;
	localparam int B1_MASS = 2;
	localparam int B1_ERASE_IRQ = 3;
	localparam int B1_IRQ_EXIT = 4;
	localparam int B1_WRITE = 6;
	localparam int B1_BLK = 7;
	localparam int B3_BUSY = 0;
	localparam int B3_KEY_FLAG = 1;
	localparam int B3_ACCV = 2;
	localparam int B3_WAIT = 3;
	localparam int B3_LOCK = 4;
	localparam int B3_EXIT = 5;
	localparam int B3_LOCKA = 6;
	localparam int B3_FAIL = 7;
	localparam int BIE_ACC_IRQ = 0;

	// ----------------------------------------------------------------
	// timing in flash timing clock ticks
	// ----------------------------------------------------------------
	localparam int PROG_TICKS = 30;
	localparam int BLOCK_WORD_TICKS = 30;
	localparam int SEG_TICKS = 32;
	localparam int ERASE_TICKS_DEFAULT = 4800;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		ACC_READ = 2'h0,
		ACC_WRITE = 2'h1,
		ACC_FETCH = 2'h2
	} access_kind_e;

	typedef enum logic [5:0] {
		S_IDLE = 6'b000001,
		S_BYTE = 6'b000010,
		S_ERASE = 6'b000100,
		S_SUSP = 6'b001000,
		S_BLK_WAIT = 6'b010000,
		S_BLK_PROG = 6'b100000
	} guard_state_e;

endpackage

// ### hdl/flash_access_guard.sv
// flash access guard: control registers, op sequencer, cpu access policing
// assumes one 20 MHz clock, cpu access strobes on that clock, flash array outside
//
// The register offsets and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
module flash_access_guard
	import flash_guard_pkg::*;
#(
	parameter int ERASE_TICKS = ERASE_TICKS_DEFAULT
)(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [flash_guard_pkg::AXI_ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [flash_guard_pkg::AXI_ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic cpu_req,
	input wire flash_guard_pkg::access_kind_e cpu_kind,
	input wire logic [15:0] cpu_addr,
	input wire logic [15:0] cpu_wdata,
	input wire logic exec_from_flash,
	output logic cpu_rvalid,
	output logic [15:0] cpu_rdata,
	input wire logic [15:0] mem_rdata,
	output logic arr_we,
	output logic arr_erase,
	output logic arr_mass,
	output logic [15:0] arr_addr,
	output logic [15:0] arr_wdata,
	input wire logic irq_pending,
	input wire logic isr_active,
	input wire logic global_interrupt_enable,
	output logic busy,
	output logic irq_mask,
	output logic nmi_req,
	output logic power_up_clear_reset
);
	import flash_guard_pkg::*;

	typedef struct packed {
		guard_state_e st;
		logic [7:0] ctl_one;
		logic [7:0] ctl_two;
		logic lock;
		logic locka;
		logic halt;
		logic acc_flag;
		logic key_flag;
		logic fail;
		logic acc_ie;
		logic from_flash;
		logic [5:0] div_cnt;
		logic [15:0] op_cnt;
		logic [4:0] seg_cnt;
		logic aw_got;
		logic [11:0] aw_addr;
		logic w_got;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic cpu_rvalid;
		logic [15:0] cpu_rdata;
		logic arr_we;
		logic arr_erase;
		logic arr_mass;
		logic [15:0] arr_addr;
		logic [15:0] arr_wdata;
		logic sys_rst;
	} guard_s;

	guard_s q;
	guard_s d;
	logic tick;
	logic busy_norm;
	logic have_aw;
	logic have_w;
	logic wr_go;
	logic [11:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic bad_key;
	logic map_ok;

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign awready = !q.aw_got && !q.bvalid;
	assign wready = !q.w_got && !q.bvalid;
	assign arready = !q.rvalid;
	assign bvalid = q.bvalid;
	assign bresp = q.bresp;
	assign rvalid = q.rvalid;
	assign rresp = q.rresp;
	assign rdata = q.rdata;
	assign cpu_rvalid = q.cpu_rvalid;
	assign cpu_rdata = q.cpu_rdata;
	assign arr_we = q.arr_we;
	assign arr_erase = q.arr_erase;
	assign arr_mass = q.arr_mass;
	assign arr_addr = q.arr_addr;
	assign arr_wdata = q.arr_wdata;
	assign power_up_clear_reset = q.sys_rst;
	// busy spans every state but idle
	assign busy = (q.st != S_IDLE);
	assign busy_norm = (q.st == S_BYTE) || (q.st == S_ERASE);
	// mask whole op unless irq exit is set; interruptible erase stays masked between boundaries
	assign irq_mask = busy && !q.ctl_one[B1_IRQ_EXIT]
		&& (!q.ctl_one[B1_ERASE_IRQ] || (q.st == S_ERASE));
	assign nmi_req = q.acc_flag && q.acc_ie;

	// ----------------------------------------------------------------
	// bus write joining
	// ----------------------------------------------------------------
	assign have_aw = q.aw_got || (awvalid && awready);
	assign have_w = q.w_got || (wvalid && wready);
	assign wr_go = have_aw && have_w && !q.bvalid;
	assign wr_addr = q.aw_got ? q.aw_addr : {awaddr[11:2], 2'b00};
	assign wr_data = q.w_got ? q.w_data : wdata;
	assign wr_strb = q.w_got ? q.w_strb : wstrb;
	assign map_ok = (wr_addr == ADDR_CTL_ONE) || (wr_addr == ADDR_CTL_TWO)
		|| (wr_addr == ADDR_CTL_THREE) || (wr_addr == ADDR_IRQ_EN);
	assign bad_key = wr_data[15:8] != WRITE_PASSWORD;
	assign tick = (q.div_cnt == q.ctl_two[5:0]);

	always_comb
	begin
		logic acc_set;
		logic lock_set;
		logic fail_set;
		logic [11:0] ra;
		acc_set = 1'b0;
		lock_set = 1'b0;
		fail_set = 1'b0;
		ra = {araddr[11:2], 2'b00};
		d = q;
		d.sys_rst = 1'b0;
		d.arr_we = 1'b0;
		d.arr_erase = 1'b0;
		d.cpu_rvalid = 1'b0;
		// flash timing clock as an enable; divider from control two
		d.div_cnt = tick ? 6'h00 : q.div_cnt + 6'h01;

		// ------------------------------------------------------------
		// operation sequencer
		// ------------------------------------------------------------
		case (q.st)
			S_BYTE:
				if (tick)
				begin
					d.op_cnt = q.op_cnt + 16'h0001;
					if (q.op_cnt == 16'(PROG_TICKS - 1))
					begin
						d.st = S_IDLE;
						d.op_cnt = 16'h0000;
					end
				end
			S_BLK_PROG:
				if (tick)
				begin
					d.op_cnt = q.op_cnt + 16'h0001;
					// word done, next may be written
					if (q.op_cnt == 16'(BLOCK_WORD_TICKS - 1))
					begin
						d.st = S_BLK_WAIT;
						d.op_cnt = 16'h0000;
					end
				end
			S_ERASE:
				if (tick)
				begin
					d.op_cnt = q.op_cnt + 16'h0001;
					d.seg_cnt = q.seg_cnt + 5'h01;
					if (q.op_cnt == 16'(ERASE_TICKS - 1))
					begin
						d.st = S_IDLE;
						d.op_cnt = 16'h0000;
						d.ctl_one[B1_ERASE] = 1'b0;
						d.ctl_one[B1_MASS] = 1'b0;
					end
					// suspend only at the 32-tick boundary
					else if (q.seg_cnt == 5'(SEG_TICKS - 1) && irq_pending
						&& q.ctl_one[B1_ERASE_IRQ] && !q.ctl_one[B1_IRQ_EXIT]
						&& global_interrupt_enable && !q.ctl_one[B1_MASS])
						d.st = S_SUSP;
				end
			S_SUSP:
				// resume gives a full 32-tick window before next stop
				if (!irq_pending && !isr_active)
				begin
					d.st = S_ERASE;
					d.seg_cnt = 5'h00;
				end
			default:
				d.op_cnt = q.op_cnt;
		endcase

		if (busy && q.st != S_SUSP && q.ctl_one[B1_IRQ_EXIT]
			&& global_interrupt_enable && irq_pending)
		begin
			d.st = S_IDLE;
			fail_set = 1'b1;
			d.op_cnt = 16'h0000;
		end

		// ------------------------------------------------------------
		// cpu flash accesses
		// ------------------------------------------------------------
		if (cpu_req)
		begin
			d.cpu_rvalid = 1'b1;
			d.cpu_rdata = mem_rdata;
			if (q.st == S_IDLE)
			begin
				if (cpu_kind == ACC_WRITE)
				begin
					if (q.lock || q.halt)
						acc_set = 1'b1;
					else if (q.ctl_one[B1_ERASE] || q.ctl_one[B1_MASS])
					begin
						d.st = S_ERASE;
						d.arr_erase = 1'b1;
						d.arr_mass = q.ctl_one[B1_MASS];
						d.arr_addr = cpu_addr;
						d.op_cnt = 16'h0000;
						d.seg_cnt = 5'h00;
						d.from_flash = exec_from_flash;
					end
					else if (q.ctl_one[B1_WRITE])
					begin
						d.st = q.ctl_one[B1_BLK] ? S_BLK_PROG : S_BYTE;
						d.arr_we = 1'b1;
						d.arr_addr = cpu_addr;
						d.arr_wdata = cpu_wdata;
						d.op_cnt = 16'h0000;
						d.from_flash = exec_from_flash;
					end
					else
						acc_set = 1'b1;
				end
			end
			else if (q.st == S_SUSP)
			begin
				// free access while the erase is parked; writes dropped
				d.cpu_rvalid = 1'b1;
			end
			else if (busy_norm)
			begin
				// loop opcode for fetches and reads
				d.cpu_rdata = JMP_SELF_OPCODE;
				if (cpu_kind == ACC_WRITE)
					acc_set = 1'b1;
				// ram-launched op: any access is a violation
				else if (!q.from_flash)
					acc_set = 1'b1;
			end
			else if (q.st == S_BLK_PROG)
			begin
				d.cpu_rdata = JMP_SELF_OPCODE;
				acc_set = 1'b1;
				lock_set = 1'b1;
			end
			else
			begin
				d.cpu_rdata = JMP_SELF_OPCODE;
				if (cpu_kind == ACC_FETCH)
				begin
					acc_set = 1'b1;
					lock_set = 1'b1;
				end
				// accepted write programs the next word
				else if (cpu_kind == ACC_WRITE)
				begin
					d.st = S_BLK_PROG;
					d.arr_we = 1'b1;
					d.arr_addr = cpu_addr;
					d.arr_wdata = cpu_wdata;
					d.op_cnt = 16'h0000;
				end
			end
		end

		// ------------------------------------------------------------
		// AXI4-Lite write channel
		// ------------------------------------------------------------
		if (q.bvalid && bready)
			d.bvalid = 1'b0;
		if (wr_go)
		begin
			d.aw_got = 1'b0;
			d.w_got = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = RESP_OKAY;
			if (!map_ok || wr_strb[1:0] != 2'b11)
				d.bresp = RESP_SLVERR;
			else if (bad_key)
			begin
				// wrong password: key flag and system reset
				d.key_flag = 1'b1;
				d.sys_rst = 1'b1;
			end
			else if (wr_addr == ADDR_CTL_ONE)
			begin
				// refuse while running or before ready
				if (busy_norm || q.st == S_BLK_PROG)
					acc_set = 1'b1;
				else
				begin
					d.ctl_one = wr_data[7:0] & CTL_ONE_MASK;
					// clearing block mode ends the block, busy drops
					if (q.st == S_BLK_WAIT && !wr_data[B1_BLK])
						d.st = S_IDLE;
				end
			end
			else if (wr_addr == ADDR_CTL_TWO)
			begin
				if (busy)
					acc_set = 1'b1;
				else
					d.ctl_two = wr_data[7:0];
			end
			else if (wr_addr == ADDR_CTL_THREE)
			begin
				d.key_flag = wr_data[B3_KEY_FLAG];
				d.acc_flag = wr_data[B3_ACCV];
				d.lock = wr_data[B3_LOCK];
				d.halt = wr_data[B3_EXIT];
				d.locka = wr_data[B3_LOCKA];
				d.fail = wr_data[B3_FAIL];
				// emergency exit overrides a start in the same cycle
				if (wr_data[B3_EXIT])
				begin
					d.st = S_IDLE;
					d.ctl_one = 8'h00;
					d.op_cnt = 16'h0000;
					// a start pulse of this cycle must not reach the array
					d.arr_we = 1'b0;
					d.arr_erase = 1'b0;
				end
			end
			else
				d.acc_ie = wr_data[BIE_ACC_IRQ];
		end
		else
		begin
			if (awvalid && awready)
			begin
				d.aw_got = 1'b1;
				d.aw_addr = {awaddr[11:2], 2'b00};
			end
			if (wvalid && wready)
			begin
				d.w_got = 1'b1;
				d.w_data = wdata;
				d.w_strb = wstrb;
			end
		end

		// ------------------------------------------------------------
		// AXI4-Lite read channel
		// ------------------------------------------------------------
		if (q.rvalid && rready)
			d.rvalid = 1'b0;
		// reads have no side effects at any time
		if (arvalid && arready)
		begin
			d.rvalid = 1'b1;
			d.rresp = RESP_OKAY;
			// read password in the upper byte
			d.rdata = {16'h0000, READ_PASSWORD, 8'h00};
			if (ra == ADDR_CTL_ONE)
				d.rdata[7:0] = q.ctl_one;
			else if (ra == ADDR_CTL_TWO)
				d.rdata[7:0] = q.ctl_two;
			else if (ra == ADDR_CTL_THREE)
				// wait low while a word or an erase is in flight
				d.rdata[7:0] = {q.fail, q.locka, q.halt, q.lock,
					!(busy_norm || q.st == S_BLK_PROG), q.acc_flag, q.key_flag, busy};
			else if (ra == ADDR_IRQ_EN)
				d.rdata = {31'h00000000, q.acc_ie};
			else
			begin
				d.rdata = 32'h00000000;
				d.rresp = RESP_SLVERR;
			end
		end

		// hardware set wins over a software clear
		d.acc_flag = d.acc_flag || acc_set;
		d.lock = d.lock || lock_set;
		// abort beats a same-cycle software clear of fail
		d.fail = d.fail || fail_set;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			q <= '0;
			q.st <= S_IDLE;
			q.ctl_one <= RST_CTL_ONE;
			q.ctl_two <= RST_CTL_TWO;
			q.lock <= 1'b1;
			q.locka <= 1'b1;
		end
		else
			q <= d;
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_key_bad;
		wr_go && map_ok && wr_strb[1:0] == 2'b11 && bad_key;
	endsequence

	property p_key_reset;
		s_key_bad |=> power_up_clear_reset && q.key_flag ##1 !power_up_clear_reset;
	endproperty
	a_key_reset: assert property (p_key_reset) else $error("bad key without reset");

	property p_read_key;
		arvalid && arready && (araddr[11:2] == ADDR_CTL_ONE[11:2]
			|| araddr[11:2] == ADDR_CTL_TWO[11:2] || araddr[11:2] == ADDR_CTL_THREE[11:2])
			|=> rvalid && rdata[15:8] == READ_PASSWORD;
	endproperty
	a_read_key: assert property (p_read_key) else $error("read key byte wrong");

	property p_fetch_jmp;
		cpu_req && cpu_kind == ACC_FETCH && busy_norm |=> cpu_rvalid && cpu_rdata == 16'h3FFF;
	endproperty
	a_fetch_jmp: assert property (p_fetch_jmp) else $error("fetch not looped");

	property p_wrt_zero;
		cpu_req && cpu_kind == ACC_WRITE && q.st == S_IDLE && !q.lock && !q.halt
			&& q.ctl_one[2:1] == 2'b00 && !q.ctl_one[B1_WRITE] |=> q.acc_flag && !arr_we;
	endproperty
	a_wrt_zero: assert property (p_wrt_zero) else $error("write enable clear not flagged");

	property p_busy_write;
		cpu_req && cpu_kind == ACC_WRITE && busy_norm |=> q.acc_flag && !arr_we;
	endproperty
	a_busy_write: assert property (p_busy_write) else $error("busy write not refused");

	property p_blk_fetch;
		cpu_req && cpu_kind == ACC_FETCH && q.st == S_BLK_WAIT |=> q.acc_flag && q.lock;
	endproperty
	a_blk_fetch: assert property (p_blk_fetch) else $error("block fetch not locked");

	property p_abort;
		busy && q.st != S_SUSP && q.ctl_one[B1_IRQ_EXIT] && global_interrupt_enable
			&& irq_pending && !cpu_req |=> !busy && q.fail;
	endproperty
	a_abort: assert property (p_abort) else $error("exit interrupt did not abort");

	property p_halt;
		wr_go && map_ok && !bad_key && wr_strb[1:0] == 2'b11 && wr_addr == ADDR_CTL_THREE
			&& wr_data[B3_EXIT] |=> !busy && q.ctl_one == 8'h00 && !arr_we && !arr_erase;
	endproperty
	a_halt: assert property (p_halt) else $error("emergency exit ignored");

	property p_mask;
		busy && !q.ctl_one[B1_ERASE_IRQ] && !q.ctl_one[B1_IRQ_EXIT] |-> irq_mask;
	endproperty
	a_mask: assert property (p_mask) else $error("interrupts not masked");

	property p_unmask;
		!busy |-> !irq_mask;
	endproperty
	a_unmask: assert property (p_unmask) else $error("interrupts masked while idle");

endmodule

// ### sim/cpu_core_model.sv
// cpu core stand-in: issues flash accesses, holds a small flash array
// assumes the guard answers every request exactly one cycle later
`timescale 1ns/1ps
module cpu_core_model
	import flash_guard_pkg::*;
(
	input wire logic aclk,
	output logic cpu_req,
	output flash_guard_pkg::access_kind_e cpu_kind,
	output logic [15:0] cpu_addr,
	output logic [15:0] cpu_wdata,
	output logic exec_from_flash,
	input wire logic cpu_rvalid,
	input wire logic [15:0] cpu_rdata,
	output logic [15:0] mem_rdata,
	input wire logic arr_we,
	input wire logic [15:0] arr_addr,
	input wire logic [15:0] arr_wdata
);
	logic [15:0] mem [128];
	logic [15:0] idle_q = 16'h5A3C;

	initial
	begin
		cpu_req = 1'b0;
		cpu_kind = ACC_READ;
		cpu_addr = 16'h0000;
		cpu_wdata = 16'h0000;
		exec_from_flash = 1'b0;
		foreach (mem[i])
			mem[i] = 16'hFFFF;
	end

	// unselected array: moving pattern, so stale data never looks right
	assign mem_rdata = cpu_req ? mem[cpu_addr[7:1]] : idle_q;

	always @(posedge aclk)
	begin
		idle_q <= ~idle_q + 16'h0013;
		if (arr_we === 1'b1)
			mem[arr_addr[7:1]] <= arr_wdata;
	end

	task automatic access(input access_kind_e kind, input logic [15:0] addr,
		input logic ff, output logic [15:0] rd, input logic [15:0] data = 16'h0000);
		@(posedge aclk);
		cpu_req <= 1'b1;
		cpu_kind <= kind;
		cpu_addr <= addr;
		cpu_wdata <= data;
		exec_from_flash <= ff;
		@(posedge aclk);
		cpu_req <= 1'b0;
		#1;
		rd = (cpu_rvalid === 1'b1) ? cpu_rdata : 16'hXXXX;
	endtask
endmodule

// ### sim/flash_access_guard_tb_top.sv
// self-checking bench for the flash access guard
// assumes the guard package and the cpu stand-in are compiled first
`timescale 1ns/1ps
module flash_access_guard_tb_top;
	import flash_guard_pkg::*;
	localparam logic [31:0] NW = 32'hFFFFFFF7;
	localparam logic [15:0] FK = 16'hA500;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [11:0] awaddr = 12'h000;
	logic [11:0] araddr = 12'h000;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hF;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic irq_pending = 1'b0, isr_active = 1'b0, global_interrupt_enable = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, cpu_req, exec_from_flash, cpu_rvalid;
	logic arr_we, arr_erase, arr_mass, busy, irq_mask, nmi_req, power_up_clear_reset;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [15:0] cpu_addr, cpu_wdata, cpu_rdata, mem_rdata, arr_addr, arr_wdata, rd;
	access_kind_e cpu_kind;
	logic reset_seen = 1'b0;
	logic [31:0] last_rd = 32'h0;
	int we_cnt = 0;
	int err_count = 0;
	int total_checks = 0;

	always #25 aclk = ~aclk;

	// erase shortened to 40 ticks for a short run
	flash_access_guard #(.ERASE_TICKS(40)) DUT (
		.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
		.rready, .cpu_req, .cpu_kind, .cpu_addr, .cpu_wdata, .exec_from_flash, .cpu_rvalid,
		.cpu_rdata, .mem_rdata, .arr_we, .arr_erase, .arr_mass, .arr_addr, .arr_wdata,
		.irq_pending, .isr_active, .global_interrupt_enable, .busy, .irq_mask, .nmi_req,
		.power_up_clear_reset
	);

	cpu_core_model cpu (
		.aclk, .cpu_req, .cpu_kind, .cpu_addr, .cpu_wdata, .exec_from_flash, .cpu_rvalid,
		.cpu_rdata, .mem_rdata, .arr_we, .arr_addr, .arr_wdata
	);

	always @(posedge aclk)
	begin
		if (power_up_clear_reset === 1'b1)
			reset_seen <= 1'b1;
		if (arr_we === 1'b1)
			we_cnt <= we_cnt + 1;
	end

	// ----
	// tasks
	// ----
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic close_out();
		$display("checks=%0d errors=%0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic give_up();
		err_count++;
		close_out();
	endtask

	task automatic axi_wr(input logic [11:0] a, input logic [15:0] d,
		input logic [1:0] er = RESP_OKAY);
		@(posedge aclk);
		awaddr <= a;
		wdata <= {16'h0000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int n = 0; n < 50; n++)
		begin
			@(posedge aclk);
			if (awvalid && awready === 1'b1)
				awvalid <= 1'b0;
			if (wvalid && wready === 1'b1)
				wvalid <= 1'b0;
			if (bvalid === 1'b1)
			begin
				bready <= 1'b0;
				check(bresp, er);
				#1;
				return;
			end
		end
		give_up();
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] e,
		input logic [31:0] m = 32'hFFFFFFFF);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int n = 0; n < 50; n++)
		begin
			@(posedge aclk);
			if (arvalid && arready === 1'b1)
				arvalid <= 1'b0;
			if (rvalid === 1'b1)
			begin
				rready <= 1'b0;
				last_rd = rdata;
				check(rdata & m, e);
				return;
			end
		end
		give_up();
	endtask

	task automatic wait_busy(input logic v);
		for (int n = 0; n < 3000; n++)
		begin
			@(posedge aclk);
			if (busy === v)
				return;
		end
		give_up();
	endtask

	// polls the ready flag in control three the way software would
	task automatic wait_ready();
		for (int n = 0; n < 300; n++)
		begin
			@(posedge aclk);
			if (busy === 1'b1 && last_rd[B3_WAIT] === 1'b1 && n > 0)
				return;
			rd_chk(ADDR_CTL_THREE, 32'h9601, NW);
		end
		give_up();
	endtask

	task automatic set_irq(input logic p, input logic s);
		@(posedge aclk);
		irq_pending <= p;
		isr_active <= s;
	endtask

	// ----
	// sequence
	// ----
	initial
	begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		rd_chk(ADDR_CTL_ONE, 32'h9600);
		rd_chk(ADDR_CTL_TWO, 32'h9642);
		rd_chk(ADDR_CTL_THREE, 32'h9658);
		axi_wr(12'h004, FK, RESP_SLVERR);
		axi_wr(ADDR_CTL_TWO, 16'hA54F);
		axi_wr(ADDR_CTL_TWO, 16'h5A41);
		rd_chk(ADDR_CTL_THREE, 32'h965A);
		check(reset_seen, 1'b1);
		rd_chk(ADDR_CTL_TWO, 32'h964F);
		axi_wr(ADDR_CTL_THREE, FK);
		cpu.access(ACC_WRITE, 16'hF000, 1'b0, rd, 16'h1234);
		rd_chk(ADDR_CTL_THREE, 32'h960C);
		check(we_cnt, 0);
		check(nmi_req, 1'b0);
		axi_wr(ADDR_IRQ_EN, 16'hA501);
		check(nmi_req, 1'b1);
		axi_wr(ADDR_CTL_THREE, FK);
		check(nmi_req, 1'b0);
		axi_wr(ADDR_CTL_ONE, 16'hA540);
		cpu.access(ACC_WRITE, 16'hF002, 1'b1, rd, 16'h1234);
		check(busy, 1'b1);
		check(irq_mask, 1'b1);
		cpu.access(ACC_FETCH, 16'hF004, 1'b1, rd);
		check(rd, JMP_SELF_OPCODE);
		cpu.access(ACC_READ, 16'hF002, 1'b1, rd);
		check(rd, JMP_SELF_OPCODE);
		rd_chk(ADDR_CTL_THREE, 32'h9601);
		cpu.access(ACC_WRITE, 16'hF006, 1'b1, rd, 16'h5555);
		rd_chk(ADDR_CTL_THREE, 32'h9605, NW);
		axi_wr(ADDR_CTL_THREE, FK);
		axi_wr(ADDR_CTL_TWO, 16'hA541);
		rd_chk(ADDR_CTL_THREE, 32'h9605, NW);
		axi_wr(ADDR_CTL_THREE, FK);
		axi_wr(ADDR_CTL_ONE, FK);
		rd_chk(ADDR_CTL_THREE, 32'h9605, NW);
		rd_chk(ADDR_CTL_ONE, 32'h9640);
		wait_busy(1'b0);
		check(irq_mask, 1'b0);
		check(we_cnt, 1);
		rd_chk(ADDR_CTL_TWO, 32'h964F);
		cpu.access(ACC_FETCH, 16'hF002, 1'b1, rd);
		check(rd, 16'h1234);
		// block flow, words paced by ready
		axi_wr(ADDR_CTL_THREE, FK);
		axi_wr(ADDR_CTL_ONE, 16'hA5C0);
		for (int i = 0; i < 3; i++)
		begin
			cpu.access(ACC_WRITE, 16'hF010 + 16'(2 * i), 1'b0, rd, 16'hB000);
			wait_ready();
			check(busy, 1'b1);
			cpu.access(ACC_READ, 16'hF010, 1'b0, rd);
			check(rd, JMP_SELF_OPCODE);
		end
		rd_chk(ADDR_CTL_THREE, 32'h9609);
		check(we_cnt, 4);
		axi_wr(ADDR_CTL_ONE, FK);
		wait_busy(1'b0);
		rd_chk(ADDR_CTL_ONE, 32'h9600);
		axi_wr(ADDR_CTL_ONE, 16'hA5C0);
		cpu.access(ACC_WRITE, 16'hF020, 1'b0, rd, 16'hC000);
		axi_wr(ADDR_CTL_ONE, 16'hA5C0);
		rd_chk(ADDR_CTL_THREE, 32'h9605);
		cpu.access(ACC_READ, 16'hF020, 1'b0, rd);
		rd_chk(ADDR_CTL_THREE, 32'h9615);
		axi_wr(ADDR_CTL_THREE, FK);
		wait_ready();
		cpu.access(ACC_FETCH, 16'hF020, 1'b0, rd);
		rd_chk(ADDR_CTL_THREE, 32'h961D);
		axi_wr(ADDR_CTL_THREE, FK);
		axi_wr(ADDR_CTL_ONE, FK);
		wait_busy(1'b0);
		// erase with suspend, then abort and emergency exit; first boundary after 32 ticks of 16 cycles
		// host keeps reset away while an erase runs
		axi_wr(ADDR_CTL_ONE, 16'hA50A);
		@(posedge aclk);
		global_interrupt_enable <= 1'b1;
		irq_pending <= 1'b1;
		cpu.access(ACC_WRITE, 16'hF040, 1'b0, rd);
		repeat (540) @(posedge aclk);
		set_irq(1'b0, 1'b1);
		check(busy, 1'b1);
		cpu.access(ACC_READ, 16'hF002, 1'b0, rd);
		check(rd, 16'h1234);
		rd_chk(ADDR_CTL_THREE, 32'h9601, NW);
		set_irq(1'b0, 1'b0);
		wait_busy(1'b0);
		rd_chk(ADDR_CTL_ONE, 32'h9608);
		axi_wr(ADDR_CTL_ONE, 16'hA512);
		cpu.access(ACC_WRITE, 16'hF040, 1'b0, rd);
		check(busy, 1'b1);
		cpu.access(ACC_READ, 16'hF002, 1'b0, rd);
		check(nmi_req, 1'b1);
		set_irq(1'b1, 1'b0);
		repeat (2) @(posedge aclk);
		#1;
		check(busy, 1'b0);
		rd_chk(ADDR_CTL_THREE, 32'h9684, NW);
		set_irq(1'b0, 1'b0);
		axi_wr(ADDR_CTL_THREE, FK);
		axi_wr(ADDR_CTL_ONE, 16'hA51A);
		cpu.access(ACC_WRITE, 16'hF040, 1'b0, rd);
		axi_wr(ADDR_CTL_THREE, 16'hA520);
		check(busy, 1'b0);
		rd_chk(ADDR_CTL_ONE, 32'h9600);
		close_out();
	end
endmodule
